// [hw/bfpt_pkg.sv]
package bfpt_pkg;
  localparam int CLK_MHZ = 50;
  localparam int PROGRAM_CYCLE_US = 5000;
  localparam int PROGRAM_CYCLE_CLKS = PROGRAM_CYCLE_US * CLK_MHZ;
  localparam int STAMP_RES_US = 1000;
  localparam int STAMP_CLKS = STAMP_RES_US * CLK_MHZ;
  localparam int RELEASE_PERCENT = 97;
  localparam int PHASE_TO_MILLI = 10;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PHASE_THR = 8'h04;
  localparam logic [7:0] ADDR_RESID_THR = 8'h08;
  localparam logic [7:0] ADDR_RETRIP_DLY = 8'h0C;
  localparam logic [7:0] ADDR_FAIL_DLY = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_EVT_TIME = 8'h18;
  localparam logic [7:0] ADDR_EVT_INFO = 8'h1C;
  localparam logic [7:0] ADDR_BLK_CUR_A = 8'h20;
  localparam logic [7:0] ADDR_BLK_CUR_B = 8'h24;
  localparam logic [7:0] ADDR_SIG_MASK = 8'h28;
  localparam logic [7:0] ADDR_RELAY_MASK = 8'h2C;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RES_LSB = 4;
  localparam int CTRL_RETRIP_EN = 6;
  localparam int CTRL_FORCE_EN = 7;
  localparam int CTRL_FORCE_BLK = 8;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [1:0] RES_RESET = 2'h0;
  localparam logic [11:0] PHASE_THR_RESET = 12'h014;
  localparam logic [15:0] RESID_THR_RESET = 16'h04B0;
  localparam logic [18:0] RETRIP_DLY_RESET = 19'h0_0014;
  localparam logic [18:0] FAIL_DLY_RESET = 19'h0_0028;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    BFPT_CUR = 4'h0, BFPT_DO = 4'h1, BFPT_SIG = 4'h2, BFPT_C_AND_D = 4'h3,
    BFPT_C_OR_D = 4'h4, BFPT_C_AND_S = 4'h5, BFPT_C_OR_S = 4'h6, BFPT_S_AND_D = 4'h7,
    BFPT_S_OR_D = 4'h8, BFPT_ANY = 4'h9, BFPT_ALL = 4'hA
  } bfpt_mode_e;
  typedef enum logic [2:0] {
    ST_NORMAL = 3'h0, ST_START = 3'h1, ST_RETRIP = 3'h2, ST_FAIL = 3'h3, ST_BLOCKED = 3'h4
  } bfpt_status_e;
endpackage : bfpt_pkg

// [hw/bfpt_top.sv]
`timescale 1ns/1ns
module bfpt_top import bfpt_pkg::*; #(
  parameter int SIG_W = 8,
  parameter int RELAY_W = 8,
  parameter int CYCLE_CLKS = PROGRAM_CYCLE_CLKS,
  parameter int MS_CLKS = STAMP_CLKS
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] phase_magnitude_l1,
  input wire logic [15:0] phase_magnitude_l2,
  input wire logic [15:0] phase_magnitude_l3,
  input wire logic [15:0] residual_input_one,
  input wire logic [15:0] residual_input_two,
  input wire logic [15:0] residual_from_phases,
  input wire logic [SIG_W-1:0] monitored_signals,
  input wire logic [RELAY_W-1:0] monitored_relays,
  input wire logic block_in,
  output logic start_out,
  output logic second_trip_out,
  output logic breaker_failure_output,
  output logic blocked_out,
  output logic display_event,
  output logic block_event
);
  logic [3:0] mode;
  logic [1:0] residual_source_select;
  logic second_trip_enable;
  logic force_enable;
  logic force_block;
  logic [11:0] phase_pickup_threshold;
  logic [15:0] residual_pickup_threshold;
  logic [18:0] second_trip_delay;
  logic [18:0] failure_delay;
  logic [SIG_W-1:0] sig_mask;
  logic [RELAY_W-1:0] relay_mask;
  logic [2:0] failure_status_code;
  logic [31:0] evt_time;
  logic [7:0] evt_info;
  logic [31:0] blk_cur_a;
  logic [31:0] blk_cur_b;

  // Program cycle and millisecond timebase.
  logic [31:0] cyc_cnt;
  logic [31:0] ms_cnt;
  logic [31:0] ms_time;
  wire cycle_tick = (cyc_cnt == 32'(CYCLE_CLKS - 1));
  wire ms_tick = (ms_cnt == 32'(MS_CLKS - 1));
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cyc_cnt <= 32'h0000_0000;
      ms_cnt <= 32'h0000_0000;
      ms_time <= 32'h0000_0000;
    end else begin
      cyc_cnt <= cycle_tick ? 32'h0000_0000 : cyc_cnt + 32'h0000_0001;
      ms_cnt <= ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
      ms_time <= ms_tick ? ms_time + 32'h0000_0001 : ms_time;
    end
  end

  // Current comparators with hysteresis.
  logic [15:0] residual_mag;
  always_comb begin
    case (residual_source_select)
      2'h1: residual_mag = residual_input_one;
      2'h2: residual_mag = residual_input_two;
      2'h3: residual_mag = residual_from_phases;
      default: residual_mag = 16'h0000;
    endcase
  end
  wire [31:0] phase_thr_milli = 32'(phase_pickup_threshold) * 32'(PHASE_TO_MILLI);
  wire [31:0] resid_thr_milli = 32'(residual_pickup_threshold);
  wire [15:0] measured_magnitude [4];
  assign measured_magnitude[0] = phase_magnitude_l1;
  assign measured_magnitude[1] = phase_magnitude_l2;
  assign measured_magnitude[2] = phase_magnitude_l3;
  assign measured_magnitude[3] = residual_mag;
  logic [3:0] picked;
  logic [3:0] next_picked;
  for (genvar i = 0; i < 4; i++) begin : g_cmp
    wire [31:0] thr = (i == 3) ? resid_thr_milli : phase_thr_milli;
    wire in_use = (i != 3) || (residual_source_select != 2'h0);
    wire over = 32'(measured_magnitude[i]) > thr;
    // Release compares the magnitude times 100 with the threshold times 97 so the 97 percent figure stays exact.
    wire held = (32'(measured_magnitude[i]) * 32'h0000_0064) >= (thr * 32'(RELEASE_PERCENT));
    assign next_picked[i] = in_use && (picked[i] ? held : over);
  end

  // Criteria are evaluated on the sampled inputs of the current program cycle.
  wire cur_c = |next_picked;
  wire crit_d = |(monitored_relays & relay_mask);
  wire crit_s = |(monitored_signals & sig_mask);
  logic pick;
  logic run;
  always_comb begin
    pick = cur_c;
    run = cur_c;
    case (mode)
      BFPT_CUR: begin
        pick = cur_c;
        run = cur_c;
      end
      BFPT_DO: begin
        pick = crit_d;
        run = crit_d;
      end
      BFPT_SIG: begin
        pick = crit_s;
        run = crit_s;
      end
      BFPT_C_AND_D: begin
        pick = cur_c;
        run = cur_c & crit_d;
      end
      BFPT_C_OR_D: begin
        pick = cur_c | crit_d;
        run = cur_c | crit_d;
      end
      BFPT_C_AND_S: begin
        pick = cur_c & crit_s;
        run = cur_c & crit_s;
      end
      BFPT_C_OR_S: begin
        pick = cur_c | crit_s;
        run = cur_c | crit_s;
      end
      BFPT_S_AND_D: begin
        pick = crit_s & crit_d;
        run = crit_s & crit_d;
      end
      BFPT_S_OR_D: begin
        pick = crit_s | crit_d;
        run = crit_s | crit_d;
      end
      BFPT_ANY: begin
        pick = cur_c | crit_d | crit_s;
        run = cur_c | crit_d | crit_s;
      end
      BFPT_ALL: begin
        pick = cur_c;
        run = cur_c & crit_d & crit_s;
      end
      default: begin
        pick = cur_c;
        run = cur_c;
      end
    endcase
  end

  // The block level is taken once per cycle, first, so a change mid-cycle cannot split a decision.
  wire blk_now = block_in | (force_enable & force_block);
  wire next_start = pick & ~blk_now;
  wire next_blocked = pick & blk_now;
  logic [18:0] tmr;
  wire [18:0] next_tmr = (next_start & run) ? ((tmr == 19'h7_FFFF) ? tmr : tmr + 19'h0_0001) :
                         (next_start ? tmr : 19'h0_0000);
  wire next_retrip = next_start & second_trip_enable & (second_trip_out | (next_tmr >= second_trip_delay));
  wire next_fail = next_start & (breaker_failure_output | (next_tmr >= failure_delay));
  wire blk_rise = cycle_tick & next_blocked & ~blocked_out;
  wire [3:0] outs_now = {blocked_out, breaker_failure_output, second_trip_out, start_out};
  wire [3:0] outs_next = {next_blocked, next_fail, next_retrip, next_start};
  wire [3:0] outs_chg = outs_now ^ outs_next;
  logic [1:0] chg_idx;
  always_comb begin
    chg_idx = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (outs_chg[k]) begin
        chg_idx = 2'(k);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      picked <= 4'h0;
      tmr <= 19'h0_0000;
      start_out <= 1'b0;
      second_trip_out <= 1'b0;
      breaker_failure_output <= 1'b0;
      blocked_out <= 1'b0;
      display_event <= 1'b0;
      block_event <= 1'b0;
      evt_time <= 32'h0000_0000;
      evt_info <= 8'h00;
      blk_cur_a <= 32'h0000_0000;
      blk_cur_b <= 32'h0000_0000;
    end else begin
      display_event <= blk_rise;
      block_event <= blk_rise;
      if (cycle_tick) begin
        picked <= next_picked;
        tmr <= next_tmr;
        start_out <= next_start;
        second_trip_out <= next_retrip;
        breaker_failure_output <= next_fail;
        blocked_out <= next_blocked;
        if (|outs_chg) begin
          evt_time <= ms_time;
          evt_info <= {3'h0, outs_next[chg_idx], outs_chg[3] & next_blocked, chg_idx, 1'b1};
        end
        if (blk_rise) begin
          blk_cur_a <= {phase_magnitude_l2, phase_magnitude_l1};
          blk_cur_b <= {residual_mag, phase_magnitude_l3};
          evt_info[7:4] <= next_picked;
        end
      end
    end
  end

  // Status code, highest condition first.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      failure_status_code <= ST_NORMAL;
    end else if (blocked_out) begin
      failure_status_code <= ST_BLOCKED;
    end else if (breaker_failure_output) begin
      failure_status_code <= ST_FAIL;
    end else if (second_trip_out) begin
      failure_status_code <= ST_RETRIP;
    end else if (start_out) begin
      failure_status_code <= ST_START;
    end else begin
      failure_status_code <= ST_NORMAL;
    end
  end

  // AXI4-Lite write path; address and data may arrive in either order.
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire wr_map = (aw_addr <= ADDR_RELAY_MASK) && (aw_addr[1:0] == 2'h0);
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge
  wire [31:0] ctrl_word = {23'h0, force_block, force_enable, second_trip_enable, residual_source_select, mode};
  wire [31:0] ctrl_new = merge(ctrl_word, w_data, w_strb);
  wire [31:0] phase_thr_new = merge(32'(phase_pickup_threshold), w_data, w_strb);
  wire [31:0] resid_thr_new = merge(32'(residual_pickup_threshold), w_data, w_strb);
  wire [31:0] retrip_dly_new = merge(32'(second_trip_delay), w_data, w_strb);
  wire [31:0] fail_dly_new = merge(32'(failure_delay), w_data, w_strb);
  wire [31:0] sig_mask_new = merge(32'(sig_mask), w_data, w_strb);
  wire [31:0] relay_mask_new = merge(32'(relay_mask), w_data, w_strb);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~aw_take & ~s_axi_awready;
      s_axi_wready <= ~w_held & ~w_take & ~s_axi_wready;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mode <= MODE_RESET;
      residual_source_select <= RES_RESET;
      second_trip_enable <= 1'b1;
      force_enable <= 1'b0;
      force_block <= 1'b0;
      phase_pickup_threshold <= PHASE_THR_RESET;
      residual_pickup_threshold <= RESID_THR_RESET;
      second_trip_delay <= RETRIP_DLY_RESET;
      failure_delay <= FAIL_DLY_RESET;
      sig_mask <= '0;
      relay_mask <= '0;
    end else if (do_write) begin
      case (aw_addr)
        ADDR_CTRL: begin
          mode <= ctrl_new[CTRL_MODE_LSB +: 4];
          residual_source_select <= ctrl_new[CTRL_RES_LSB +: 2];
          second_trip_enable <= ctrl_new[CTRL_RETRIP_EN];
          force_enable <= ctrl_new[CTRL_FORCE_EN];
          // The switch only counts while forcing is on, and is dropped when forcing is turned off.
          force_block <= ctrl_new[CTRL_FORCE_BLK] & ctrl_new[CTRL_FORCE_EN];
        end
        ADDR_PHASE_THR: phase_pickup_threshold <= phase_thr_new[11:0];
        ADDR_RESID_THR: residual_pickup_threshold <= resid_thr_new[15:0];
        ADDR_RETRIP_DLY: second_trip_delay <= retrip_dly_new[18:0];
        ADDR_FAIL_DLY: failure_delay <= fail_dly_new[18:0];
        ADDR_SIG_MASK: sig_mask <= sig_mask_new[SIG_W-1:0];
        ADDR_RELAY_MASK: relay_mask <= relay_mask_new[RELAY_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // AXI4-Lite read path; one read at a time, answer one cycle after the address is taken.
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      ADDR_CTRL: rd_word = ctrl_word;
      ADDR_PHASE_THR: rd_word = 32'(phase_pickup_threshold);
      ADDR_RESID_THR: rd_word = 32'(residual_pickup_threshold);
      ADDR_RETRIP_DLY: rd_word = second_trip_enable ? 32'(second_trip_delay) : 32'h0000_0000;
      ADDR_FAIL_DLY: rd_word = 32'(failure_delay);
      ADDR_STATUS: rd_word = {20'h0, picked, blocked_out, breaker_failure_output, second_trip_out, start_out,
                              1'b0, failure_status_code};
      ADDR_EVT_TIME: rd_word = evt_time;
      ADDR_EVT_INFO: rd_word = {24'h0, evt_info};
      ADDR_BLK_CUR_A: rd_word = blk_cur_a;
      ADDR_BLK_CUR_B: rd_word = blk_cur_b;
      ADDR_SIG_MASK: rd_word = 32'(sig_mask);
      ADDR_RELAY_MASK: rd_word = 32'(relay_mask);
      default: begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end
  wire ar_take = s_axi_arvalid & s_axi_arready;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take & ~s_axi_arready;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : bfpt_top

// [tb/bfpt_checker.sv]
`timescale 1ns/1ns
module bfpt_checker (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic start_out,
  input wire logic second_trip_out,
  input wire logic breaker_failure_output,
  input wire logic blocked_out,
  input wire logic display_event,
  input wire logic block_event
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  start_blk_a: assert property (blocked_out |-> !start_out) else $error("start while blocked");
  blk_notrip_a: assert property (blocked_out |-> !second_trip_out && !breaker_failure_output)
    else $error("trip while blocked");
  trip_start_a: assert property ((second_trip_out || breaker_failure_output) |-> start_out)
    else $error("trip without start");
  trip_drop_a: assert property ($fell(start_out) && $past(breaker_failure_output)
    |-> $fell(breaker_failure_output)) else $error("failure output outlived start");
  block_pulse_a: assert property ($rose(blocked_out) |-> ##[0:1] (display_event && block_event))
    else $error("no event on blocking");
  pulse_one_a: assert property (block_event |=> !block_event) else $error("event longer than a cycle");
  event_cause_a: assert property ($rose(block_event) |-> blocked_out) else $error("event without blocking");
  // The start, trip and blocked outputs move only on program-cycle ticks, so any change is followed by a quiet stretch.
  start_hold_a: assert property ($changed(start_out) |=> ($stable(start_out))[*8])
    else $error("start changed between ticks");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : bfpt_checker

// [tb/bfpt_far_side.sv]
`timescale 1ns/1ns
module bfpt_far_side (
  input wire logic clk_sys,
  input wire logic [5:0][15:0] want_mag,
  input wire logic [7:0] want_sig,
  input wire logic [7:0] want_rel,
  input wire logic want_blk,
  output logic [15:0] mag_l1,
  output logic [15:0] mag_l2,
  output logic [15:0] mag_l3,
  output logic [15:0] res_one,
  output logic [15:0] res_two,
  output logic [15:0] res_calc,
  output logic [7:0] sig_out,
  output logic [7:0] rel_out,
  output logic blk_out
);
  // Measurements, trips and the block all move on a clock edge, like other logic of the program.
  always_ff @(posedge clk_sys) begin
    {res_calc, res_two, res_one, mag_l3, mag_l2, mag_l1} <= want_mag;
    sig_out <= want_sig;
    rel_out <= want_rel;
    blk_out <= want_blk;
  end
endmodule : bfpt_far_side

// [tb/bfpt_tb_top.sv]
`timescale 1ns/1ns
module bfpt_tb_top import bfpt_pkg::*;;
  localparam int CYC = 10;
  logic clk_sys = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, want_blk = 0;
  logic [7:0] awaddr = 0, araddr = 0, want_sig = 0, want_rel = 0;
  logic [31:0] wdata = 0, rd;
  logic [1:0] rsp;
  logic [5:0][15:0] want_mag = '0;
  wire logic awready, wready, bvalid, arready, rvalid, st, rt, ft, bo, blk;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] m1, m2, m3, r1, r2, rc;
  wire logic [7:0] sig, rel;
  int err_total = 0, checks = 0, seed = 93491, t0, c, d, s, k;
  logic [7:0] ra [7] = '{ADDR_CTRL, ADDR_PHASE_THR, ADDR_RESID_THR, ADDR_RETRIP_DLY, ADDR_FAIL_DLY, ADDR_STATUS,
    ADDR_SIG_MASK};
  logic [31:0] rv [7] = '{32'h0000_0040, 32'h0000_0014, 32'h0000_04B0, 32'h0000_0014, 32'h0000_0028, 0, 0};
  always #10 clk_sys = ~clk_sys;
  bfpt_far_side FAR (.clk_sys(clk_sys), .want_mag(want_mag), .want_sig(want_sig), .want_rel(want_rel),
    .want_blk(want_blk), .mag_l1(m1), .mag_l2(m2), .mag_l3(m3), .res_one(r1), .res_two(r2), .res_calc(rc),
    .sig_out(sig), .rel_out(rel), .blk_out(blk));
  bfpt_top #(.CYCLE_CLKS(CYC), .MS_CLKS(4)) DUT (.clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .phase_magnitude_l1(m1), .phase_magnitude_l2(m2), .phase_magnitude_l3(m3), .residual_input_one(r1),
    .residual_input_two(r2), .residual_from_phases(rc), .monitored_signals(sig), .monitored_relays(rel),
    .block_in(blk), .start_out(st), .second_trip_out(rt), .breaker_failure_output(ft), .blocked_out(bo),
    .display_event(), .block_event());
  task automatic close_out;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic lost;
    err_total++;
    $display("ERROR wait expected answer seen none");
    close_out();
  endtask : lost
  // The response ready is raised late at random so that a held response is exercised too.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int i, lag;
    lag = $unsigned($random(seed)) % 3;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        rsp = bresp;
        bready <= 1'b0;
        break;
      end
      if (i >= lag) bready <= 1'b1;
    end
    if (i == 200) lost();
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    int i, lag;
    lag = $unsigned($random(seed)) % 3;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        break;
      end
      if (i >= lag) rready <= 1'b1;
    end
    if (i == 200) lost();
  endtask : rdr
  task automatic ticks(input int n);
    repeat (n * CYC) @(posedge clk_sys);
  endtask : ticks
  // Counts clocks until the chosen output (0 start, 1 second trip, 2 failure) reaches the level.
  task automatic wait_sig(input int w, input logic lvl);
    for (t0 = 0; t0 < 2000; t0++) begin
      @(posedge clk_sys);
      if ((w == 0 ? st : (w == 1 ? rt : ft)) === lvl) break;
    end
    if (t0 == 2000) lost();
  endtask : wait_sig
  function automatic logic exp_start(input int m, input logic c, input logic d, input logic s);
    case (m)
      1: return d;
      2: return s;
      4: return c | d;
      5: return c & s;
      6: return c | s;
      7: return s & d;
      8: return s | d;
      9: return c | d | s;
      default: return c;
    endcase
  endfunction : exp_start
  initial begin
    repeat (100000) @(posedge clk_sys);
    lost();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (k = 0; k < 7; k++) begin
      rdr(ra[k]);
      chk("reset value", rd, rv[k]);
    end
    rdr(8'h30);
    chk("unmapped read", 32'(rsp), 32'(RESP_SLVERR));
    wr(8'h32, 32'h0000_0001);
    chk("unmapped write", 32'(rsp), 32'(RESP_SLVERR));
    wr(ADDR_RETRIP_DLY, 32'h0000_0003);
    wr(ADDR_FAIL_DLY, 32'h0000_0005);
    want_mag[1] <= 16'h00C9;
    wait_sig(0, 1'b1);
    wait_sig(1, 1'b1);
    chk("second trip delay", t0, 2 * CYC - 1);
    wait_sig(2, 1'b1);
    chk("failure delay", t0, 2 * CYC - 1);
    rdr(ADDR_STATUS);
    chk("status code", 32'(rd[2:0]), 32'(ST_FAIL));
    want_mag[1] <= 16'h00C3;
    ticks(2);
    chk("start in hysteresis", 32'(st), 32'h0000_0001);
    want_mag[1] <= 16'h00C1;
    ticks(2);
    chk("trips released", 32'({st, rt, ft}), 32'h0000_0000);
    want_mag[0] <= 16'h012C;
    wait_sig(0, 1'b1);
    want_blk <= 1'b1;
    ticks(2);
    chk("blocked outputs", 32'({st, rt, ft, bo}), 32'h0000_0001);
    rdr(ADDR_STATUS);
    chk("blocked status", 32'(rd[2:0]), 32'(ST_BLOCKED));
    rdr(ADDR_BLK_CUR_A);
    chk("block currents", rd, 32'h00C1_012C);
    rdr(ADDR_EVT_INFO);
    chk("block fault type", 32'(rd[7:4]), 32'h0000_0001);
    want_blk <= 1'b0;
    wait_sig(0, 1'b1);
    wait_sig(1, 1'b1);
    chk("timer restart", t0, 2 * CYC - 1);
    wr(ADDR_CTRL, 32'h0000_01C0);
    ticks(2);
    chk("forced block", 32'({st, bo}), 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0000);
    wait_sig(0, 1'b1);
    wait_sig(2, 1'b1);
    chk("failure delay alone", t0, 4 * CYC - 1);
    chk("no second trip", 32'(rt), 32'h0000_0000);
    rdr(ADDR_RETRIP_DLY);
    chk("retrip delay hidden", rd, 32'h0000_0000);
    want_mag <= {32'h0000_0000, 16'h04B1, 48'h0000_0000_0000};
    ticks(2);
    chk("unused residual", 32'(st), 32'h0000_0000);
    want_mag <= '0;
    wr(ADDR_RELAY_MASK, 32'h0000_0001);
    wr(ADDR_SIG_MASK, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0043);
    want_mag[2] <= 16'h0190;
    wait_sig(0, 1'b1);
    ticks(5);
    chk("halted timer", 32'(rt), 32'h0000_0000);
    want_rel <= 8'h01;
    wait_sig(1, 1'b1);
    chk("timer ran after relay", 32'(t0 > CYC), 32'h0000_0001);
    for (k = 0; k < 33; k++) begin
      wr(ADDR_CTRL, 32'h0000_0040 | (32'(k % 3 + 1) << 4) | 32'(k / 3));
      want_mag <= '0;
      want_sig <= 8'h00;
      want_rel <= 8'h00;
      ticks(2);
      c = $unsigned($random(seed)) % 2;
      d = $unsigned($random(seed)) % 2;
      s = $unsigned($random(seed)) % 4;
      want_mag[s == 3 ? 3 + k % 3 : s] <= s == 3 ? (c ? 16'h04B1 : 16'h04AF) : (c ? 16'h00C9 : 16'h00C7);
      s = $unsigned($random(seed)) % 2;
      want_rel <= 8'(d);
      want_sig <= 8'(s);
      ticks(2);
      chk("start by mode", 32'(st), 32'(exp_start(k / 3, c[0], d[0], s[0])));
    end
    close_out();
  end
endmodule : bfpt_tb_top
bind bfpt_top bfpt_checker CHK (.clk_sys(clk_sys), .rst_b(rst_b), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .start_out(start_out),
  .second_trip_out(second_trip_out), .breaker_failure_output(breaker_failure_output),
  .blocked_out(blocked_out), .display_event(display_event), .block_event(block_event));
